// file: file_ram.sv
//****************************************************************
// Shared constants and types
//****************************************************************
package exec_pkg;
  // Register byte offsets on the control bus
  localparam logic [7:0] REG_ISSUE = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0C;
  localparam logic [7:0] REG_STATE = 8'h10;
  localparam logic [7:0] REG_FILE_PTR = 8'h14;
  localparam logic [7:0] REG_FILE_DATA = 8'h18;
  // Status flag bit positions
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_OV_BIT = 3;
  localparam int FLAG_N_BIT = 4;
  // State register bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NOP_BIT = 1;
  localparam int ST_PHASE_LSB = 2;
  localparam int ST_TAKEN_BIT = 4;
  localparam int ST_BAD_BIT = 5;
  // Opcode upper bytes and nibbles
  localparam logic [7:0] OPB_CARRY_SET = 8'hE2;
  localparam logic [7:0] OPB_CARRY_CLR = 8'hE3;
  localparam logic [7:0] OPB_OVF_CLR = 8'hE5;
  localparam logic [7:0] OPB_NEG_SET = 8'hE6;
  localparam logic [7:0] OPB_NEG_CLR = 8'hE7;
  localparam logic [3:0] OPN_BIT_CLEAR = 4'h9;
  // Program counter and file addressing
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam int FILE_AW = 12;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    Q1_DECODE = 2'b00,
    Q2_READ = 2'b01,
    Q3_PROCESS = 2'b10,
    Q4_WRITE = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_BRANCH = 2'b01,
    KIND_BITCLR = 2'b10
  } kind_t;
endpackage

`timescale 1ns/1ns
`default_nettype none

//****************************************************************
// File register memory with registered read data
//****************************************************************
module file_ram
  import exec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [FILE_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:(1<<FILE_AW)-1];

  // Write and read-before-write port
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // file_ram

`default_nettype wire

// file: cond_branch_bit_clear_exec.sv
// How it works
// - Byte E6 branches when negative set
// - Byte E3 branches when carry clear
// - Byte E7 branches when negative clear
// - Byte E5 branches when overflow clear
// - Target is incremented counter plus twice offset
// - Taken branch adds one no-operation cycle
// - Four phases: decode, read, process, write
// - Every opcode is one word, counter steps two
// - Nibble 9 clears selected file bit, flags kept
// - Access flag zero picks access bank
// - Byte E2 branches when carry set
`timescale 1ns/1ns
`default_nettype none
module cond_branch_bit_clear_exec
  import exec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_busy,
  output logic [15:0] o_pc
);
  //**************************************************************
  // State
  //**************************************************************
  typedef struct packed {
    phase_t phase;
    kind_t kind;
    logic busy, nop, taken, last_taken, bad_op;
    logic [15:0] opcode, pc, target;
    logic [4:0] flags;
    logic [3:0] bank;
    logic [FILE_AW-1:0] fptr, faddr;
    logic [7:0] fdata;
    logic awready, aw_held;
    logic [7:0] awaddr;
    logic wready, w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready, rd_pend, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_reg, st_next;
  logic mem_we, cond_met;
  logic [FILE_AW-1:0] mem_addr, eff_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [15:0] br_offset;
  logic [31:0] wval;
  //**************************************************************
  // Helpers
  //**************************************************************
  // Register read mux
  function automatic logic [31:0] reg_read(input logic [7:0] a, input state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      REG_ISSUE: r[15:0] = s.opcode;
      REG_FLAGS: r[4:0] = s.flags;
      REG_PC: r[15:0] = s.pc;
      REG_BANK: r[3:0] = s.bank;
      REG_STATE: begin
        r[ST_BUSY_BIT] = s.busy;
        r[ST_NOP_BIT] = s.nop;
        r[ST_PHASE_LSB +: 2] = s.phase;
        r[ST_TAKEN_BIT] = s.last_taken;
        r[ST_BAD_BIT] = s.bad_op;
      end
      REG_FILE_PTR: r[FILE_AW-1:0] = s.fptr;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == REG_ISSUE) || (a == REG_FLAGS) || (a == REG_PC) || (a == REG_BANK) ||
           (a == REG_STATE) || (a == REG_FILE_PTR) || (a == REG_FILE_DATA);
  endfunction
  // Byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[8*b +: 8] = n[8*b +: 8];
      end
    end
    return m;
  endfunction
  // Sign-extended doubled offset and branch condition
  always_comb begin
    br_offset = {{7{st_reg.opcode[7]}}, st_reg.opcode[7:0], 1'b0};
    unique case (st_reg.opcode[15:8])
      OPB_NEG_SET: cond_met = st_reg.flags[FLAG_N_BIT];
      OPB_CARRY_CLR: cond_met = !st_reg.flags[FLAG_C_BIT];
      OPB_NEG_CLR: cond_met = !st_reg.flags[FLAG_N_BIT];
      OPB_OVF_CLR: cond_met = !st_reg.flags[FLAG_OV_BIT];
      OPB_CARRY_SET: cond_met = st_reg.flags[FLAG_C_BIT];
      default: cond_met = 1'b0;
    endcase
  end
  // Effective file address, access bank when flag is zero
  always_comb begin
    if (st_reg.opcode[8]) begin
      eff_addr = {st_reg.bank, st_reg.opcode[7:0]};
    end else if (st_reg.opcode[7:0] < ACCESS_SPLIT) begin
      eff_addr = {ACCESS_LO_BANK, st_reg.opcode[7:0]};
    end else begin
      eff_addr = {ACCESS_HI_BANK, st_reg.opcode[7:0]};
    end
  end

  //**************************************************************
  // Next state
  //**************************************************************
  always_comb begin
    st_next = st_reg;
    mem_we = 1'b0;
    mem_addr = st_reg.fptr;
    mem_wdata = st_reg.fdata;
    wval = merge(reg_read(st_reg.awaddr, st_reg), st_reg.wdata, st_reg.wstrb);
    // Write address and data capture
    if (i_awvalid && st_reg.awready) begin
      st_next.awaddr = i_awaddr;
      st_next.aw_held = 1'b1;
      st_next.awready = 1'b0;
    end
    if (i_wvalid && st_reg.wready) begin
      st_next.wdata = i_wdata;
      st_next.wstrb = i_wstrb;
      st_next.w_held = 1'b1;
      st_next.wready = 1'b0;
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    // Write commit, held off while an instruction runs
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid && !st_reg.busy) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.awaddr)
        REG_ISSUE: begin
          st_next.opcode = wval[15:0];
          st_next.busy = 1'b1;
          st_next.nop = 1'b0;
          st_next.taken = 1'b0;
          st_next.phase = Q1_DECODE;
        end
        REG_FLAGS: st_next.flags = wval[4:0];
        REG_PC: st_next.pc = {wval[15:1], 1'b0};
        REG_BANK: st_next.bank = wval[3:0];
        REG_FILE_PTR: st_next.fptr = wval[FILE_AW-1:0];
        REG_FILE_DATA: begin
          mem_we = st_reg.wstrb[0];
          mem_wdata = st_reg.wdata[7:0];
        end
        REG_STATE: st_next.bresp = RESP_OKAY;
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.rd_pend) begin
      st_next.rd_pend = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rdata = {24'h00_0000, mem_rdata};
      st_next.rresp = RESP_OKAY;
    end
    if (i_arvalid && st_reg.arready) begin
      if (i_araddr == REG_FILE_DATA) begin
        st_next.rd_pend = 1'b1;
      end else begin
        st_next.rvalid = 1'b1;
        st_next.rdata = reg_read(i_araddr, st_reg);
        st_next.rresp = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
    // Instruction phases
    if (st_reg.busy) begin
      unique case (st_reg.phase)
        Q1_DECODE: begin
          st_next.phase = Q2_READ;
          if (!st_reg.nop) begin
            st_next.pc = st_reg.pc + PC_STEP;
            st_next.bad_op = 1'b0;
            if (st_reg.opcode[15:12] == OPN_BIT_CLEAR) begin
              st_next.kind = KIND_BITCLR;
            end else if ((st_reg.opcode[15:8] == OPB_NEG_SET) ||
                         (st_reg.opcode[15:8] == OPB_CARRY_CLR) ||
                         (st_reg.opcode[15:8] == OPB_NEG_CLR) ||
                         (st_reg.opcode[15:8] == OPB_OVF_CLR) ||
                         (st_reg.opcode[15:8] == OPB_CARRY_SET)) begin
              st_next.kind = KIND_BRANCH;
            end else begin
              st_next.kind = KIND_NONE;
              st_next.bad_op = 1'b1;
            end
          end
        end
        Q2_READ: begin
          st_next.phase = Q3_PROCESS;
          if (!st_reg.nop && st_reg.kind == KIND_BITCLR) begin
            st_next.faddr = eff_addr;
            mem_addr = eff_addr;
          end
        end
        Q3_PROCESS: begin
          st_next.phase = Q4_WRITE;
          if (!st_reg.nop) begin
            st_next.target = st_reg.pc + br_offset;
            st_next.taken = (st_reg.kind == KIND_BRANCH) && cond_met;
            st_next.fdata = mem_rdata & ~(8'h01 << st_reg.opcode[11:9]);
          end
        end
        Q4_WRITE: begin
          st_next.phase = Q1_DECODE;
          if (st_reg.nop) begin
            st_next.busy = 1'b0;
            st_next.nop = 1'b0;
          end else begin
            st_next.last_taken = st_reg.taken;
            if (st_reg.kind == KIND_BITCLR) begin
              mem_we = 1'b1;
              mem_addr = st_reg.faddr;
              mem_wdata = st_reg.fdata;
            end
            if (st_reg.taken) begin
              st_next.pc = st_reg.target;
              st_next.nop = 1'b1;
            end else begin
              st_next.busy = 1'b0;
            end
          end
        end
      endcase
    end
    // No new read while an instruction or a reply is pending
    st_next.arready = !st_next.rvalid && !st_next.rd_pend && !st_next.busy;
  end
  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  file_ram u_file_ram (
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );
  // Outputs straight from state
  assign o_awready = st_reg.awready;
  assign o_wready = st_reg.wready;
  assign o_bresp = st_reg.bresp;
  assign o_bvalid = st_reg.bvalid;
  assign o_arready = st_reg.arready;
  assign o_rdata = st_reg.rdata;
  assign o_rresp = st_reg.rresp;
  assign o_rvalid = st_reg.rvalid;
  assign o_busy = st_reg.busy;
  assign o_pc = st_reg.pc;

  //**************************************************************
  // Checks
  //**************************************************************
  logic q4_first;
  assign q4_first = st_reg.busy && !st_reg.nop && (st_reg.phase == Q4_WRITE);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  a_neg_set_cond: assert property (q4_first && st_reg.opcode[15:8] == OPB_NEG_SET
    |-> st_reg.taken == st_reg.flags[FLAG_N_BIT]) else $error("negative branch condition");
  a_carry_clr_cond: assert property (q4_first && st_reg.opcode[15:8] == OPB_CARRY_CLR
    |-> st_reg.taken == !st_reg.flags[FLAG_C_BIT]) else $error("carry clear condition");
  a_neg_clr_cond: assert property (q4_first && st_reg.opcode[15:8] == OPB_NEG_CLR
    |-> st_reg.taken == !st_reg.flags[FLAG_N_BIT]) else $error("not negative condition");
  a_ovf_clr_cond: assert property (q4_first && st_reg.opcode[15:8] == OPB_OVF_CLR
    |-> st_reg.taken == !st_reg.flags[FLAG_OV_BIT]) else $error("no overflow condition");
  a_carry_set_cond: assert property (q4_first && st_reg.opcode[15:8] == OPB_CARRY_SET
    |-> st_reg.taken == st_reg.flags[FLAG_C_BIT]) else $error("carry set condition");
  a_branch_target: assert property (q4_first && st_reg.taken
    |=> st_reg.pc == $past(st_reg.pc) + $past(br_offset)) else $error("bad branch target");
  a_taken_nop_cycle: assert property (q4_first && st_reg.taken
    |=> (st_reg.busy && st_reg.nop)[*4] ##1 !st_reg.busy) else $error("taken cycle count");
  a_phase_order: assert property (st_reg.busy && st_reg.phase == Q1_DECODE
    |=> st_reg.phase == Q2_READ ##1 st_reg.phase == Q3_PROCESS ##1 st_reg.phase == Q4_WRITE)
    else $error("phase order broken");
  a_one_word: assert property (st_reg.busy && !st_reg.nop && st_reg.phase == Q1_DECODE
    |=> st_reg.pc == $past(st_reg.pc) + PC_STEP) else $error("counter step wrong");
  a_bit_clear_write: assert property (q4_first && st_reg.kind == KIND_BITCLR
    |-> mem_we && mem_addr == st_reg.faddr && !mem_wdata[st_reg.opcode[11:9]])
    else $error("bit clear write wrong");
  a_access_bank: assert property (st_reg.busy && !st_reg.nop && st_reg.phase == Q2_READ &&
    st_reg.kind == KIND_BITCLR && !st_reg.opcode[8]
    |-> mem_addr == {(st_reg.opcode[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), st_reg.opcode[7:0]})
    else $error("access bank not used");
  a_fall_through: assert property (q4_first && !st_reg.taken
    |=> !st_reg.busy && $stable(st_reg.pc)) else $error("untaken branch moved counter");
  a_flags_kept: assert property (st_reg.busy |=> $stable(st_reg.flags))
    else $error("flags changed during instruction");
  c_taken_branch: cover property (q4_first && st_reg.kind == KIND_BRANCH && st_reg.taken);
  c_untaken_branch: cover property (q4_first && st_reg.kind == KIND_BRANCH && !st_reg.taken);
  c_bit_clear: cover property (q4_first && st_reg.kind == KIND_BITCLR);
endmodule // cond_branch_bit_clear_exec

`default_nettype wire

// file: test_cond_branch_bit_clear_exec.sv
`timescale 1ns/1ns
`default_nettype none

module test_cond_branch_bit_clear_exec;
  import exec_pkg::*;
  //****************************************************************
  // Signals
  //****************************************************************
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_awaddr = 8'h00;
  logic i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0] i_wstrb = 4'hF;
  logic i_wvalid = 1'b0;
  logic i_bready = 1'b0;
  logic [7:0] i_araddr = 8'h00;
  logic i_arvalid = 1'b0;
  logic i_rready = 1'b0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [15:0] o_pc;
  int mismatches = 0;
  int num_checks = 0;
  int busy_cnt = 0;

  cond_branch_bit_clear_exec cond_branch_bit_clear_exec_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_busy(o_busy), .o_pc(o_pc)
  );

  // Clock and busy cycle counter
  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (o_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  //****************************************************************
  // Compare and bus tasks
  //****************************************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t response got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_cycles(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH %0t busy cycles got %0d expected %0d", $time, got, exp);
    end
  endtask

  // Write one word, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(ad && wd) && n < 1000) begin
      @(posedge i_mclk);
      n++;
      if (!ad && o_awready === 1'b1) begin
        ad = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!wd && o_wready === 1'b1) begin
        wd = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    while (o_bvalid !== 1'b1 && n < 1000) begin
      @(posedge i_mclk);
      n++;
    end
    i_bready <= 1'b0;
    check_resp(o_bresp, er);
  endtask

  // Read one word
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_arready !== 1'b1 && n < 1000);
    i_arvalid <= 1'b0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_rvalid !== 1'b1 && n < 1000);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check_word(d, exp);
    check_resp(r, RESP_OKAY);
  endtask

  // Issue one opcode and count the cycles busy stays high
  task automatic issue(input logic [15:0] op, input int exp);
    int s;
    int n;
    s = busy_cnt;
    n = 0;
    wr(REG_ISSUE, {16'h0000, op}, RESP_OKAY);
    while (o_busy === 1'b1 && n < 1000) begin
      @(posedge i_mclk);
      n++;
    end
    @(posedge i_mclk);
    check_cycles(busy_cnt - s, exp);
  endtask

  //****************************************************************
  // Scenarios
  //****************************************************************
  task automatic test_reset;
    check_word({16'h0000, o_pc}, 32'h0000_0000);
    check_word({31'h0, o_busy}, 32'h0000_0000);
    rd_chk(REG_PC, 32'h0000_0000);
    rd_chk(REG_STATE, 32'h0000_0000);
  endtask

  // Every branch code, taken and not taken, at one offset extreme each, alternating between codes
  task automatic test_branches;
    logic [7:0] ops [5] = '{OPB_CARRY_SET, OPB_CARRY_CLR, OPB_OVF_CLR, OPB_NEG_SET, OPB_NEG_CLR};
    int bits [5] = '{FLAG_C_BIT, FLAG_C_BIT, FLAG_OV_BIT, FLAG_N_BIT, FLAG_N_BIT};
    logic pol [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0] n8;
    logic [31:0] fl;
    logic [15:0] pc;
    for (int i = 0; i < 5; i++) begin
      for (int t = 0; t < 2; t++) begin
        n8 = (i % 2) ? 8'h7F : 8'h80;
        fl = 32'h0000_0019;
        fl[bits[i]] = (t == 1) ? pol[i] : ~pol[i];
        pc = 16'h0202;
        if (t == 1) pc = pc + {{7{n8[7]}}, n8, 1'b0};
        wr(REG_PC, 32'h0000_0200, RESP_OKAY);
        wr(REG_FLAGS, fl, RESP_OKAY);
        issue({ops[i], n8}, (t == 1) ? 8 : 4);
        rd_chk(REG_STATE, (t == 1) ? (32'h0000_0001 << ST_TAKEN_BIT) : 32'h0000_0000);
        rd_chk(REG_PC, {16'h0000, pc});
        check_word({16'h0000, o_pc}, {16'h0000, pc});
        rd_chk(REG_FLAGS, fl);
      end
    end
  endtask

  // Bit clear through the bank register and both halves of the access bank
  task automatic test_bit_clear;
    logic [15:0] ops [3] = '{16'h9FA5, 16'h9485, 16'h9010};
    logic [31:0] ptr [3] = '{32'h3A5, 32'hF85, 32'h010};
    logic [31:0] twin [3] = '{32'hFA5, 32'h385, 32'h310};
    logic [31:0] pre [3] = '{32'hC7, 32'hFF, 32'hFF};
    logic [31:0] post [3] = '{32'h47, 32'hFB, 32'hFE};
    for (int i = 0; i < 3; i++) begin
      wr(REG_BANK, 32'h0000_0003, RESP_OKAY);
      wr(REG_FILE_PTR, twin[i], RESP_OKAY);
      wr(REG_FILE_DATA, 32'h0000_00FF, RESP_OKAY);
      wr(REG_FILE_PTR, ptr[i], RESP_OKAY);
      wr(REG_FILE_DATA, pre[i], RESP_OKAY);
      wr(REG_FLAGS, 32'h0000_0019, RESP_OKAY);
      wr(REG_PC, 32'h0000_0040, RESP_OKAY);
      issue(ops[i], 4);
      rd_chk(REG_FILE_DATA, post[i]);
      rd_chk(REG_FLAGS, 32'h0000_0019);
      rd_chk(REG_PC, 32'h0000_0042);
      wr(REG_FILE_PTR, twin[i], RESP_OKAY);
      rd_chk(REG_FILE_DATA, 32'h0000_00FF);
    end
  endtask

  task automatic test_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h1C, d, r);
    check_word(d, 32'h0000_0000);
    check_resp(r, RESP_SLVERR);
    wr(8'h20, 32'h0000_00A5, RESP_SLVERR);
    // Bank register readback, then an opcode outside the decoded set
    wr(REG_BANK, 32'h0000_0005, RESP_OKAY);
    rd_chk(REG_BANK, 32'h0000_0005);
    wr(REG_FLAGS, 32'h0000_0019, RESP_OKAY);
    wr(REG_PC, 32'h0000_0100, RESP_OKAY);
    issue(16'hE105, 4);
    rd_chk(REG_PC, 32'h0000_0102);
    rd_chk(REG_STATE, 32'h0000_0001 << ST_BAD_BIT);
    rd_chk(REG_FLAGS, 32'h0000_0019);
  endtask

  //****************************************************************
  // Verdict, main sequence and watchdog
  //****************************************************************
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    test_reset();
    test_branches();
    test_bit_clear();
    test_unmapped();
    complete_run();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    complete_run();
  end
endmodule // test_cond_branch_bit_clear_exec

`default_nettype wire
